// >>> src/hsl_lane_select.sv
`timescale 1ns/1ns

module hsl_lane_select
  import hsl_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              rst_i,
  input  wire logic              capture_i,
  input  wire logic [1:0]        op_i,
  input  wire logic [1:0]        lane_i,
  input  wire logic              big_i,
  input  wire logic [DATA_W-1:0] rdata_i,
  output logic      [DATA_W-1:0] value_o
);

  logic [BYTE_W-1:0] sel_byte;
  logic [HALF_W-1:0] sel_half;
  logic [DATA_W-1:0] next_value;

  // --------------------
  // lane choice by address bits and endianness
  // --------------------
  always_comb begin
    if (big_i) begin
      sel_byte = rdata_i[(3 - lane_i) * BYTE_W +: BYTE_W];
      sel_half = lane_i[1] ? rdata_i[HALF_W-1:0]
                           : rdata_i[DATA_W-1:HALF_W];
    end else begin
      sel_byte = rdata_i[lane_i * BYTE_W +: BYTE_W];
      sel_half = lane_i[1] ? rdata_i[DATA_W-1:HALF_W]
                           : rdata_i[HALF_W-1:0];
    end
  end

  // --------------------
  // extension; bit 0 of a half address is simply ignored
  // --------------------
  always_comb begin
    case (op_i)
      OP_S_BYTE: next_value = {{(DATA_W-BYTE_W){sel_byte[BYTE_W-1]}},
                               sel_byte};
      OP_S_HALF: next_value = {{(DATA_W-HALF_W){sel_half[HALF_W-1]}},
                               sel_half};
      OP_U_HALF: next_value = {{(DATA_W-HALF_W){1'b0}}, sel_half};
      default:   next_value = '0;
    endcase
  end

  // registered so the core write comes from a flop
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      value_o <= '0;
    end else if (capture_i) begin
      value_o <= next_value;
    end
  end

endmodule : hsl_lane_select

// >>> src/hsl_load_store.sv
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/1ns

module hsl_load_store
  import hsl_pkg::*;
(
  input  wire logic               clock_i,
  input  wire logic               rst_i,
  // request from the core
  input  wire logic               req_i,
  input  wire logic               sign_i,
  input  wire logic               half_i,
  input  wire logic               load_i,
  input  wire logic [DATA_W-1:0]  base_i,
  input  wire logic [DATA_W-1:0]  offset_i,
  input  wire logic               up_i,
  input  wire logic               pre_i,
  input  wire logic               wback_i,
  input  wire logic [DATA_W-1:0]  instr_addr_i,
  input  wire logic               base_pc_i,
  input  wire logic               src_pc_i,
  input  wire logic               dest_pc_i,
  input  wire logic [DATA_W-1:0]  src_data_i,
  // memory side
  input  wire logic [DATA_W-1:0]  mem_rdata_i,
  input  wire logic               mem_abort_i,
  // register port
  input  wire logic [RADDR_W-1:0] reg_addr_i,
  input  wire logic [DATA_W-1:0]  reg_wdata_i,
  input  wire logic               reg_wr_i,
  input  wire logic               reg_rd_i,
  output logic      [DATA_W-1:0]  reg_rdata_o,
  // memory side outputs
  output logic      [DATA_W-1:0]  mem_addr_o,
  output logic      [DATA_W-1:0]  mem_wdata_o,
  output logic                    mem_req_o,
  output logic                    mem_write_o,
  output logic      [1:0]         mem_size_o,
  output logic      [1:0]         cycle_type_o,
  // results to the core
  output logic                    busy_o,
  output logic      [DATA_W-1:0]  dest_data_o,
  output logic                    dest_we_o,
  output logic      [DATA_W-1:0]  wb_data_o,
  output logic                    wb_we_o,
  output logic                    done_o,
  output logic                    abort_trap_o
);

  // --------------------
  // helpers
  // --------------------

  // add or subtract the offset, used for both index forms
  function automatic logic [DATA_W-1:0] apply_offset(
    input logic [DATA_W-1:0] base,
    input logic [DATA_W-1:0] offs,
    input logic              up
  );
    apply_offset = up ? base + offs : base - offs;
  endfunction : apply_offset

  // counter step; a count in the clearing cycle still adds one
  function automatic logic [DATA_W-1:0] count_step(
    input logic [DATA_W-1:0] cnt,
    input logic              clr,
    input logic              inc
  );
    logic [DATA_W-1:0] base;
    base = clr ? '0 : cnt;
    count_step = inc ? base + 32'h0000_0001 : base;
  endfunction : count_step

  // --------------------
  // state
  // --------------------
  hsl_state_type     state;
  hsl_state_type     next_state;
  logic              big_endian_select;
  logic              abort_sticky;
  logic              abort_seen;
  logic [1:0]        op;
  logic              to_pc;
  logic              do_wb;
  logic [DATA_W-1:0] wb_value;
  logic [DATA_W-1:0] seq_cnt;
  logic [DATA_W-1:0] nonseq_cnt;
  logic [DATA_W-1:0] int_cnt;
  logic [DATA_W-1:0] lane_value;
  logic [DATA_W-1:0] eff_base;
  logic [DATA_W-1:0] moved_base;
  logic [DATA_W-1:0] xfer_addr;
  logic [DATA_W-1:0] store_src;
  logic [1:0]        req_op;
  logic              start;
  logic [1:0]        next_cycle;

  // --------------------
  // request decode and address arithmetic
  // --------------------

  // flags to kind; a signed store is not legal and reads as a store
  always_comb begin
    if (!load_i) begin
      req_op = OP_HALF_STORE;
    end else if (sign_i) begin
      req_op = half_i ? OP_S_HALF : OP_S_BYTE;
    end else begin
      req_op = OP_U_HALF;
    end
  end

  assign start = req_i && (state == ST_IDLE);
  // pc seen through the pipeline, two fetches ahead
  assign eff_base = base_pc_i ? instr_addr_i + PC_BASE_OFFSET
                              : base_i;
  assign moved_base = apply_offset(eff_base, offset_i, up_i);
  assign xfer_addr = pre_i ? moved_base : eff_base;
  // pc source is one more fetch on than the base view
  assign store_src = src_pc_i ? instr_addr_i + PC_STORE_OFFSET
                              : src_data_i;

  // --------------------
  // sequencer
  // --------------------

  // cycle order: load N I S, pc load N I N S S, store N N
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (req_i) begin
          next_state = (req_op == OP_HALF_STORE) ? ST_STORE_ADDR
                                                 : ST_XFER;
        end
      end
      ST_STORE_ADDR: next_state = ST_XFER;
      ST_XFER: begin
        next_state = (op == OP_HALF_STORE) ? ST_IDLE : ST_WRITE;
      end
      ST_WRITE: next_state = to_pc ? ST_REFILL_N : ST_FETCH;
      ST_FETCH: next_state = ST_IDLE;
      ST_REFILL_N: next_state = ST_REFILL_S;
      ST_REFILL_S: next_state = ST_FETCH;
      default: next_state = ST_IDLE;
    endcase
  end

  // cycle type that the coming state presents
  always_comb begin
    case (next_state)
      ST_STORE_ADDR: next_cycle = CYC_NONSEQ;
      ST_XFER: next_cycle = CYC_NONSEQ;
      ST_WRITE: next_cycle = CYC_INTERNAL;
      ST_FETCH: next_cycle = CYC_SEQ;
      ST_REFILL_N: next_cycle = CYC_NONSEQ;
      ST_REFILL_S: next_cycle = CYC_SEQ;
      default: next_cycle = CYC_NONE;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      cycle_type_o <= CYC_NONE;
      busy_o <= 1'b0;
    end else begin
      state <= next_state;
      cycle_type_o <= next_cycle;
      busy_o <= (next_state != ST_IDLE);
    end
  end

  // request fields held for the whole instruction
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      op <= OP_HALF_STORE;
      to_pc <= 1'b0;
      do_wb <= 1'b0;
      wb_value <= '0;
    end else if (start) begin
      op <= req_op;
      to_pc <= dest_pc_i && load_i;
      // post index always moves the base; pc base never written back
      do_wb <= (wback_i || !pre_i) && !base_pc_i;
      wb_value <= moved_base;
    end
  end

  // --------------------
  // memory side
  // --------------------

  // address and data launched on entry to a load's transfer cycle or a store's address cycle
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      mem_addr_o <= '0;
      mem_wdata_o <= '0;
      mem_req_o <= 1'b0;
      mem_write_o <= 1'b0;
      mem_size_o <= SIZE_HALF;
    end else if (start) begin
      mem_addr_o <= xfer_addr;
      mem_wdata_o <= {store_src[HALF_W-1:0],
                      store_src[HALF_W-1:0]};
      mem_write_o <= (req_op == OP_HALF_STORE);
      // size lets memory enable one byte lane for a signed byte load, else one half lane
      mem_size_o <= (req_op == OP_S_BYTE) ? SIZE_BYTE
                                          : SIZE_HALF;
      mem_req_o <= (req_op != OP_HALF_STORE);
    end else if (state == ST_STORE_ADDR) begin
      mem_req_o <= 1'b1;
    end else if (state == ST_XFER) begin
      mem_req_o <= 1'b0;
      mem_write_o <= 1'b0;
    end
  end

  // fault rejects the transfer; trap reported at completion
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      abort_seen <= 1'b0;
    end else if (start) begin
      abort_seen <= 1'b0;
    end else if (state == ST_XFER && mem_abort_i) begin
      abort_seen <= 1'b1;
    end
  end

  // lane choice uses the address on the bus this very transfer
  hsl_lane_select u_lanes (
    .clock_i   (clock_i),
    .rst_i     (rst_i),
    .capture_i (state == ST_XFER),
    .op_i      (op),
    .lane_i    (mem_addr_o[1:0]),
    .big_i     (big_endian_select),
    .rdata_i   (mem_rdata_i),
    .value_o   (lane_value)
  );

  // --------------------
  // results to the core
  // --------------------

  // loaded value and base update in the internal cycle, a store's base update in its transfer cycle
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      dest_data_o <= '0;
      dest_we_o <= 1'b0;
      wb_data_o <= '0;
      wb_we_o <= 1'b0;
    end else begin
      dest_we_o <= 1'b0;
      wb_we_o <= 1'b0;
      if (state == ST_WRITE) begin
        // an aborted load leaves the destination untouched
        dest_we_o <= !abort_seen;
        dest_data_o <= lane_value;
        wb_we_o <= do_wb;
        wb_data_o <= wb_value;
      end else if (state == ST_XFER && op == OP_HALF_STORE) begin
        wb_we_o <= do_wb;
        wb_data_o <= wb_value;
      end
    end
  end

  // completion pulse and the trap that goes with it
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      done_o <= 1'b0;
      abort_trap_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      abort_trap_o <= 1'b0;
      if (state != ST_IDLE && next_state == ST_IDLE) begin
        done_o <= 1'b1;
        abort_trap_o <= abort_seen ||
                        (state == ST_XFER && mem_abort_i);
      end
    end
  end

  // --------------------
  // register port
  // --------------------

  // endian control; writes take effect from the next cycle, even for a load in flight
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      big_endian_select <= CTRL_BIG_RESET;
    end else if (reg_wr_i && reg_addr_i == REG_CTRL) begin
      big_endian_select <= reg_wdata_i[CTRL_BIG_BIT];
    end
  end

  // sticky abort flag, write one to clear, a new abort wins
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      abort_sticky <= 1'b0;
    end else if (state == ST_XFER && mem_abort_i) begin
      abort_sticky <= 1'b1;
    end else if (reg_wr_i && reg_addr_i == REG_STATUS &&
                 reg_wdata_i[STAT_ABORT_BIT]) begin
      abort_sticky <= 1'b0;
    end
  end

  // cycle counters; a write to a counter clears it, a cycle in flight still counts
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      seq_cnt <= '0;
      nonseq_cnt <= '0;
      int_cnt <= '0;
    end else begin
      seq_cnt <= count_step(seq_cnt,
                            reg_wr_i && reg_addr_i == REG_SEQ_CNT,
                            cycle_type_o == CYC_SEQ);
      nonseq_cnt <= count_step(nonseq_cnt,
                               reg_wr_i && reg_addr_i == REG_NONSEQ_CNT,
                               cycle_type_o == CYC_NONSEQ);
      int_cnt <= count_step(int_cnt,
                            reg_wr_i && reg_addr_i == REG_INT_CNT,
                            cycle_type_o == CYC_INTERNAL);
    end
  end

  // read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        REG_CTRL: begin
          reg_rdata_o <= '0;
          reg_rdata_o[CTRL_BIG_BIT] <= big_endian_select;
        end
        REG_STATUS: begin
          reg_rdata_o <= '0;
          reg_rdata_o[STAT_BUSY_BIT] <= busy_o;
          reg_rdata_o[STAT_ABORT_BIT] <= abort_sticky;
        end
        REG_SEQ_CNT: reg_rdata_o <= seq_cnt;
        REG_NONSEQ_CNT: reg_rdata_o <= nonseq_cnt;
        REG_INT_CNT: reg_rdata_o <= int_cnt;
        REG_LAST_DATA: reg_rdata_o <= dest_data_o;
        default: reg_rdata_o <= '0;
      endcase
    end else begin
      reg_rdata_o <= '0;
    end
  end

endmodule : hsl_load_store

// >>> src/hsl_pkg.sv
package hsl_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W = 32;
  localparam int unsigned HALF_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned RADDR_W = 5;

  // ----------------------------------------------------------------
  // transfer kinds, as the core hands them over
  // ----------------------------------------------------------------
  localparam logic [1:0] OP_HALF_STORE = 2'h0;
  localparam logic [1:0] OP_U_HALF = 2'h1;
  localparam logic [1:0] OP_S_BYTE = 2'h2;
  localparam logic [1:0] OP_S_HALF = 2'h3;

  // ----------------------------------------------------------------
  // bus size codes and cycle type codes
  // ----------------------------------------------------------------
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] CYC_NONE = 2'h0;
  localparam logic [1:0] CYC_SEQ = 2'h1;
  localparam logic [1:0] CYC_NONSEQ = 2'h2;
  localparam logic [1:0] CYC_INTERNAL = 2'h3;

  // ----------------------------------------------------------------
  // program counter offsets in bytes
  // ----------------------------------------------------------------
  localparam logic [31:0] PC_BASE_OFFSET = 32'h0000_0008;
  localparam logic [31:0] PC_STORE_OFFSET = 32'h0000_000C;

  // ----------------------------------------------------------------
  // register map (byte addresses) and fields
  // ----------------------------------------------------------------
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h04;
  localparam logic [4:0] REG_SEQ_CNT = 5'h08;
  localparam logic [4:0] REG_NONSEQ_CNT = 5'h0C;
  localparam logic [4:0] REG_INT_CNT = 5'h10;
  localparam logic [4:0] REG_LAST_DATA = 5'h14;
  localparam int unsigned CTRL_BIG_BIT = 0;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_ABORT_BIT = 1;
  localparam logic CTRL_BIG_RESET = 1'b0;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_XFER,
    ST_WRITE,
    ST_FETCH,
    ST_REFILL_N,
    ST_REFILL_S,
    ST_STORE_ADDR
  } hsl_state_type;

endpackage : hsl_pkg

// >>> verif/hsl_load_store_props.sv
`timescale 1ns/1ns

module hsl_load_store_props
  import hsl_pkg::*;
(
  input wire logic               clock_i,
  input wire logic               rst_i,
  input wire logic               req_i,
  input wire logic               sign_i,
  input wire logic               half_i,
  input wire logic               load_i,
  input wire logic [DATA_W-1:0]  base_i,
  input wire logic [DATA_W-1:0]  offset_i,
  input wire logic               up_i,
  input wire logic               pre_i,
  input wire logic [DATA_W-1:0]  instr_addr_i,
  input wire logic               base_pc_i,
  input wire logic               src_pc_i,
  input wire logic               dest_pc_i,
  input wire logic [DATA_W-1:0]  src_data_i,
  input wire logic [DATA_W-1:0]  mem_rdata_i,
  input wire logic               mem_abort_i,
  input wire logic [RADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0]  reg_wdata_i,
  input wire logic               reg_wr_i,
  input wire logic [DATA_W-1:0]  mem_addr_o,
  input wire logic [DATA_W-1:0]  mem_wdata_o,
  input wire logic               mem_req_o,
  input wire logic               mem_write_o,
  input wire logic [1:0]         cycle_type_o,
  input wire logic               busy_o,
  input wire logic [DATA_W-1:0]  dest_data_o,
  input wire logic               dest_we_o,
  input wire logic               done_o,
  input wire logic               abort_trap_o
);
  // --------------------
  // shadow of endian bit, request and read word
  // --------------------
  logic [DATA_W-1:0] rd_q, pa_q, sd_q, bb, ea, w, exp_v;
  logic [1:0]        ln_q;
  logic              s_q, h_q, big_q, take;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  // request accepted only while idle
  assign take = req_i && !busy_o;
  assign bb = base_pc_i ? instr_addr_i + PC_BASE_OFFSET : base_i;
  assign ea = up_i ? bb + offset_i : bb - offset_i;

  // endian bit as software last wrote it
  always_ff @(posedge clock_i) begin
    if (rst_i)
      big_q <= CTRL_BIG_RESET;
    else if (reg_wr_i && reg_addr_i == REG_CTRL)
      big_q <= reg_wdata_i[CTRL_BIG_BIT];
  end

  // capture request fields and the word seen in the transfer cycle
  always_ff @(posedge clock_i) begin
    if (take) begin
      s_q <= sign_i;
      h_q <= half_i;
      pa_q <= pre_i ? ea : bb;
      sd_q <= src_pc_i ? instr_addr_i + PC_STORE_OFFSET : src_data_i;
    end
    if (mem_req_o && !mem_write_o) begin
      rd_q <= mem_rdata_i;
      ln_q <= mem_addr_o[1:0];
    end
  end

  // expected value: lane by endian and low address, then extension
  always_comb begin
    if (h_q)
      w = (big_q ^ ln_q[1]) ? rd_q >> 16 : rd_q;
    else
      w = rd_q >> (big_q ? 24 - 8 * ln_q : 8 * ln_q);
    if (!s_q)
      exp_v = {16'h0000, w[15:0]};
    else if (h_q)
      exp_v = {{16{w[15]}}, w[15:0]};
    else
      exp_v = {{24{w[7]}}, w[7:0]};
  end

  property p_byte_lane;
    dest_we_o && s_q && !h_q |-> dest_data_o == exp_v;
  endproperty
  a_byte_lane: assert property (p_byte_lane)
    else $error("signed byte lane or extension wrong");

  property p_half_lane;
    dest_we_o && (h_q || !s_q) |-> dest_data_o == exp_v;
  endproperty
  a_half_lane: assert property (p_half_lane)
    else $error("half word lane or extension wrong");

  property p_load_seq;
    take && load_i && !dest_pc_i |=> cycle_type_o == CYC_NONSEQ
      && mem_req_o ##1 cycle_type_o == CYC_INTERNAL
      ##1 cycle_type_o == CYC_SEQ ##1 done_o && !busy_o;
  endproperty
  a_load_seq: assert property (p_load_seq)
    else $error("load cycle sequence wrong");

  property p_pc_load;
    take && load_i && dest_pc_i |=> cycle_type_o == CYC_NONSEQ
      ##1 cycle_type_o == CYC_INTERNAL ##1 cycle_type_o == CYC_NONSEQ
      ##1 cycle_type_o == CYC_SEQ ##1 cycle_type_o == CYC_SEQ ##1 done_o;
  endproperty
  a_pc_load: assert property (p_pc_load)
    else $error("load into pc cycle sequence wrong");

  property p_store;
    take && !load_i |=> cycle_type_o == CYC_NONSEQ && mem_write_o
      && !mem_req_o ##1 cycle_type_o == CYC_NONSEQ && mem_req_o
      && mem_write_o ##1 done_o;
  endproperty
  a_store: assert property (p_store)
    else $error("half store cycle sequence wrong");

  property p_store_data;
    take && !load_i |-> ##2 mem_wdata_o == {sd_q[15:0], sd_q[15:0]};
  endproperty
  a_store_data: assert property (p_store_data)
    else $error("store data not repeated low half");

  property p_addr;
    take && load_i |=> mem_addr_o == pa_q;
  endproperty
  a_addr: assert property (p_addr)
    else $error("transfer address wrong");

  property p_abort_trap;
    mem_req_o && mem_abort_i |-> ##[1:5] done_o && abort_trap_o;
  endproperty
  a_abort_trap: assert property (p_abort_trap)
    else $error("abort trap missing");

  property p_abort_nowr;
    mem_req_o && !mem_write_o && mem_abort_i |-> ##2 !dest_we_o;
  endproperty
  a_abort_nowr: assert property (p_abort_nowr)
    else $error("aborted load wrote destination");
endmodule : hsl_load_store_props

bind hsl_load_store hsl_load_store_props i_hsl_load_store_props (.*);

// >>> verif/hsl_load_store_tb.sv
`timescale 1ns/1ns

module hsl_load_store_tb
  import hsl_pkg::*;
;
  logic         clock_i, rst_i, req_i, sign_i, half_i, load_i, up_i;
  logic         pre_i, wback_i, base_pc_i, src_pc_i, dest_pc_i, fault;
  logic         reg_wr_i, reg_rd_i, mem_abort_i, mem_req_o, mem_write_o;
  logic         busy_o, dest_we_o, wb_we_o, done_o, abort_trap_o, trap;
  logic [31:0]  base_i, offset_i, instr_addr_i, src_data_i, reg_wdata_i;
  logic [31:0]  mem_rdata_i, reg_rdata_o, mem_addr_o, mem_wdata_o, got;
  logic [31:0]  dest_data_o, wb_data_o, wbv;
  logic [4:0]   reg_addr_i;
  logic [1:0]   mem_size_o, cycle_type_o;
  int           n_mismatch = 0;
  int           samples_checked = 0;

  hsl_load_store i_hsl_load_store (.*);

  hsl_mem_model i_hsl_mem_model (
    .clock_i, .fault_i(fault), .mem_req_i(mem_req_o),
    .mem_write_i(mem_write_o), .mem_addr_i(mem_addr_o),
    .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i),
    .mem_abort_o(mem_abort_i)
  );

  // 100 ns period
  always #50 clock_i = ~clock_i;

  // --------------------
  // bus tasks and comparison
  // --------------------
  task print_verdict;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict

  task cmp32(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp32

  task reg_wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
  endtask : reg_wr

  // read data stands only in the cycle after the strobe
  task chk_reg(input logic [4:0] a, input logic [31:0] e);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    #1 cmp32(reg_rdata_o, e);
  endtask : chk_reg

  task clr_cnt;
    reg_wr(REG_SEQ_CNT, 32'h0000_0000);
    reg_wr(REG_NONSEQ_CNT, 32'h0000_0000);
    reg_wr(REG_INT_CNT, 32'h0000_0000);
  endtask : clr_cnt

  task chk_cnt(input logic [31:0] s, input logic [31:0] n,
               input logic [31:0] i);
    chk_reg(REG_SEQ_CNT, s);
    chk_reg(REG_NONSEQ_CNT, n);
    chk_reg(REG_INT_CNT, i);
  endtask : chk_cnt

  // one instruction; bounded wait so a hang ends the run
  task go(input logic s, input logic h, input logic l,
          input logic [31:0] b);
    int k;
    got = 32'hA5A5_A5A5;
    wbv = got;
    @(posedge clock_i);
    {sign_i, half_i, load_i, base_i, req_i} <= {s, h, l, b, 1'b1};
    @(posedge clock_i);
    req_i <= 1'b0;
    for (k = 0; k < 20; k++) begin
      #1;
      if (dest_we_o === 1'b1)
        got = dest_data_o;
      if (wb_we_o === 1'b1)
        wbv = wb_data_o;
      if (done_o === 1'b1)
        break;
      @(posedge clock_i);
    end
    trap = abort_trap_o;
    if (k == 20) begin
      n_mismatch++;
      print_verdict();
    end
  endtask : go

  function automatic logic [31:0] ld_exp(input logic [31:0] wd,
      input logic [1:0] ln, input logic bg, input logic s, input logic h);
    logic [31:0] w;
    if (h)
      w = (bg ^ ln[1]) ? wd >> 16 : wd;
    else
      w = wd >> (bg ? 24 - 8 * ln : 8 * ln);
    if (!s)
      return {16'h0000, w[15:0]};
    if (h)
      return {{16{w[15]}}, w[15:0]};
    return {{24{w[7]}}, w[7:0]};
  endfunction : ld_exp

  // --------------------
  // scenarios
  // --------------------
  // every lane, load kind and endian setting; halves keep address bit 0 low
  task t_lanes;
    int k;
    int bg;
    logic [1:0] ln;
    logic [31:0] e;
    chk_reg(REG_CTRL, 32'h0000_0000);
    i_hsl_mem_model.mem[0] = 32'h7E8F_C13A;
    for (bg = 0; bg < 2; bg++) begin
      reg_wr(REG_CTRL, 32'(bg));
      for (k = 0; k < 12; k++) begin
        ln = 2'(k % 4);
        if (k < 4 || !ln[0]) begin
          go(k < 8, k >= 4, 1'b1, {30'h0, ln});
          e = ld_exp(32'h7E8F_C13A, ln, bg[0], k < 8, k >= 4);
          cmp32(got, e);
          cmp32({30'h0, mem_size_o}, 32'(k >= 4));
        end
      end
    end
    reg_wr(REG_CTRL, 32'h0000_0000);
  endtask : t_lanes

  // half stores: repeated data, memory half enable, pc source, cycles
  task t_store;
    i_hsl_mem_model.mem[1] = 32'h5555_5555;
    src_data_i <= 32'h1234_ABCD;
    clr_cnt();
    go(1'b0, 1'b1, 1'b0, 32'h0000_0006);
    cmp32(mem_wdata_o, 32'hABCD_ABCD);
    cmp32(i_hsl_mem_model.mem[1], 32'hABCD_5555);
    chk_cnt(32'h0, 32'h2, 32'h0);
    @(posedge clock_i);
    {src_pc_i, instr_addr_i} <= {1'b1, 32'h0000_0100};
    go(1'b0, 1'b1, 1'b0, 32'h0000_0004);
    cmp32(mem_wdata_o, 32'h010C_010C);
    @(posedge clock_i);
    src_pc_i <= 1'b0;
  endtask : t_store

  // pc as base, then pc as destination; address, data and cycle counts
  task t_pc;
    i_hsl_mem_model.mem[3] = 32'h0000_8001;
    @(posedge clock_i);
    {base_pc_i, instr_addr_i, offset_i} <= {1'b1, 32'h0, 32'h4};
    clr_cnt();
    go(1'b0, 1'b1, 1'b1, 32'hFFFF_FFF0);
    cmp32(mem_addr_o, 32'h0000_000C);
    cmp32(got, 32'h0000_8001);
    chk_cnt(32'h1, 32'h1, 32'h1);
    @(posedge clock_i);
    dest_pc_i <= 1'b1;
    clr_cnt();
    go(1'b1, 1'b1, 1'b1, 32'h0);
    cmp32(got, 32'hFFFF_8001);
    chk_cnt(32'h2, 32'h2, 32'h1);
    @(posedge clock_i);
    {base_pc_i, dest_pc_i, offset_i} <= '0;
  endtask : t_pc

  // faults on a load and a store, sticky flag, unmapped place
  task t_abort;
    i_hsl_mem_model.mem[2] = 32'h1111_1111;
    @(posedge clock_i);
    fault <= 1'b1;
    go(1'b1, 1'b1, 1'b1, 32'h0);
    cmp32({31'h0, trap}, 32'h1);
    cmp32(got, 32'hA5A5_A5A5);
    go(1'b0, 1'b1, 1'b0, 32'h0000_0008);
    cmp32({31'h0, trap}, 32'h1);
    cmp32(i_hsl_mem_model.mem[2], 32'h1111_1111);
    chk_reg(REG_STATUS, 32'h0000_0002);
    @(posedge clock_i);
    fault <= 1'b0;
    reg_wr(REG_STATUS, 32'h0000_0002);
    chk_reg(REG_STATUS, 32'h0000_0000);
    reg_wr(5'h1C, 32'hFFFF_FFFF);
    chk_reg(5'h1C, 32'h0000_0000);
    {pre_i, offset_i} <= {1'b0, 32'h4};
    go(1'b1, 1'b0, 1'b1, 32'h0000_0003);
    cmp32({31'h0, trap}, 32'h0);
    cmp32(got, 32'h0000_007E);
    cmp32(wbv, 32'h0000_0007);
    cmp32(mem_addr_o, 32'h0000_0003);
  endtask : t_abort

  // main sequence
  initial begin
    clock_i = 1'b0;
    rst_i = 1'b1;
    {req_i, sign_i, half_i, load_i, wback_i, base_pc_i} = '0;
    {src_pc_i, dest_pc_i, fault, reg_wr_i, reg_rd_i} = '0;
    {up_i, pre_i} = 2'b11;
    {base_i, offset_i, instr_addr_i, src_data_i, reg_wdata_i} = '0;
    reg_addr_i = 5'h00;
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    t_lanes();
    t_store();
    t_pc();
    t_abort();
    print_verdict();
  end
endmodule : hsl_load_store_tb

// >>> verif/hsl_mem_model.sv
`timescale 1ns/1ns

module hsl_mem_model
  import hsl_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              fault_i,
  input  wire logic              mem_req_i,
  input  wire logic              mem_write_i,
  input  wire logic [DATA_W-1:0] mem_addr_i,
  input  wire logic [DATA_W-1:0] mem_wdata_i,
  output logic      [DATA_W-1:0] mem_rdata_o,
  output logic                   mem_abort_o
);
  logic [DATA_W-1:0] mem [0:3];
  logic [DATA_W-1:0] last = '0;
  logic              rd;

  assign rd = mem_req_i && !mem_write_i;
  // manager rejects only a transfer the bench marks faulty
  assign mem_abort_o = mem_req_i && fault_i;
  // released bus shows the inverse of the last word, never a stale copy
  assign mem_rdata_o = rd ? mem[mem_addr_i[3:2]] : ~last;

  // only the addressed half is enabled, so repeated data lands once
  always @(posedge clock_i) begin
    if (rd)
      last <= mem_rdata_o;
    if (mem_req_i && mem_write_i && !fault_i) begin
      if (mem_addr_i[1])
        mem[mem_addr_i[3:2]][31:16] <= mem_wdata_i[31:16];
      else
        mem[mem_addr_i[3:2]][15:0] <= mem_wdata_i[15:0];
    end
  end
endmodule : hsl_mem_model
